//--- hdl/pcs_pkg.sv
// Purpose: constants shared by the reference clock switchover block
// Assumes: one 10 MHz system clock, reference inputs sampled on it
// Notes: register map and timing counts live here and nowhere else
package pcs_pkg;

    // =========================================================
    // clock and timing
    // =========================================================
    localparam int CLK_PERIOD_NS = 100;
    // cycles a sampled reference may sit still before it is declared lost
    localparam int LOSS_CYCLES = 2;
    // cycles the manual request must stay high after its rising edge
    localparam int MANUAL_HOLD_CYCLES = 3;
    localparam int CNT_W = 2;
    localparam int SWCOUNT_W = 16;

    // =========================================================
    // register map (byte addresses)
    // =========================================================
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;
    localparam logic [7:0] SWCOUNT_OFFSET = 8'h08;

    // ctrl fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SWREQ_BIT = 4;
    // status fields
    localparam int STATUS_LOSS0_BIT = 0;
    localparam int STATUS_LOSS1_BIT = 1;
    localparam int STATUS_ACTIVE_BIT = 2;
    localparam int STATUS_PEND_BIT = 3;

    // =========================================================
    // modes and reset values
    // =========================================================
    typedef enum logic [1:0] {
        PCS_MODE_MANUAL = 2'b00,
        PCS_MODE_AUTO = 2'b01,
        PCS_MODE_AUTO_OVR = 2'b10
    } pcs_mode_t;

    localparam logic [1:0] CTRL_MODE_RESET = 2'b01;
    localparam logic SEL_RESET = 1'b0;

endpackage

//--- hdl/pcs_switchover.sv
// Purpose: reference clock switchover with loss detection and APB registers
// Assumes: reference clocks and manual request are synchronous to clk_i
// Notes: the reference mux output is a sampled copy, rate limited to clk_i / 2
//        references must change level at least every second cycle (clk_i / 4 or faster) or the detector sees them stop
//        the loop behind ref_clock_o is not modelled here; its reset is left to the user
//
// What this block does
// - manual mode: request rising and held three cycles swaps primary and backup
// - automatic mode: selected reference stops toggling, switch to the other input
// - override mode: a high manual request beats automatic loss selection
// - two loss flags and a selected-input indicator go out to user logic
// - switchover state machine drives the mux select picking the reference
// - automatic switchovers may alternate any number of times
// - active lost while other also lost: no switchover, flags undefined
// - loss flag rises when the detector sees its input stop toggling
// - loss flags unreliable beyond 20 percent frequency difference
// - selected-input indicator always shows which input drives the loop
// - input still about two cycles raises its flag; if selected, it moves the mux in automatic mode, or in override mode with the request low
// - the change happens on a falling edge of the surviving clock
// - unequal but in-range frequencies still get stopped clock detection
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module pcs_switchover #(
    parameter int ADDR_W = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // reference clocks and user request
    input wire logic primary_ref_clock_i,
    input wire logic backup_ref_clock_i,
    input wire logic manual_switch_i,
    // to the loop and to user logic
    output logic ref_clock_o,
    output logic [1:0] loss_flag_o,
    output logic active_input_o,
    output logic switched_o
);

    // =========================================================
    // declarations
    // =========================================================
    typedef enum logic {
        PCS_ST_RUN,
        PCS_ST_PEND
    } pcs_state_t;

    // loss detector state, one slot per reference input
    logic [1:0] ref_in;
    logic [1:0] smp_q, smp_d;
    logic [pcs_pkg::CNT_W-1:0] idle_cnt_q [2];
    logic [pcs_pkg::CNT_W-1:0] idle_cnt_d [2];
    logic [1:0] loss_q, loss_d;
    logic smp_vld_q, smp_vld_d;

    // manual request qualifier
    logic req_prev_q, req_prev_d;
    logic [pcs_pkg::CNT_W-1:0] hold_cnt_q, hold_cnt_d;
    logic armed_q, armed_d;
    logic manual_fire;
    logic req_level;

    // switchover machine and mux
    pcs_state_t state_q, state_d;
    logic sel_q, sel_d;
    logic ref_q, ref_d;
    logic switched_q, switched_d;
    logic [pcs_pkg::SWCOUNT_W-1:0] swcount_q, swcount_d;
    logic auto_en, manual_en, auto_fire;
    logic target;

    // register file and apb response
    logic [1:0] mode_q, mode_d;
    logic swreq_q, swreq_d;
    logic [31:0] prdata_q, prdata_d;
    logic pready_q, pready_d;
    logic pslverr_q, pslverr_d;
    logic access;

    // decode an address to a register slot: 0 ctrl, 1 status, 2 count, 3 none
    // read and write paths share it, so the two can never disagree on the map
    function automatic logic [1:0] reg_slot(input logic [ADDR_W-1:0] addr);
        logic [1:0] slot;
        slot = 2'd3;
        if (addr == ADDR_W'(pcs_pkg::CTRL_OFFSET)) begin
            slot = 2'd0;
        end else if (addr == ADDR_W'(pcs_pkg::STATUS_OFFSET)) begin
            slot = 2'd1;
        end else if (addr == ADDR_W'(pcs_pkg::SWCOUNT_OFFSET)) begin
            slot = 2'd2;
        end
        return slot;
    endfunction

    assign ref_in = {backup_ref_clock_i, primary_ref_clock_i};

    // =========================================================
    // loss of clock detection
    // =========================================================
    // each input counts cycles without a level change; reaching the limit
    // declares it lost, any change clears it at once
    // a stopped reference may sit high or low, so only the lack of change counts
    // the counter stops at the limit, so a long stop never wraps and drops
    // the flag by itself
    always_comb begin
        smp_d = ref_in;
        // the first sample after reset has no real predecessor to compare with
        smp_vld_d = 1'b1;
        loss_d = loss_q;
        for (int i = 0; i < 2; i++) begin
            idle_cnt_d[i] = idle_cnt_q[i];
            if (!smp_vld_q || (ref_in[i] != smp_q[i])) begin
                idle_cnt_d[i] = '0;
                loss_d[i] = 1'b0;
            end else if (idle_cnt_q[i] < pcs_pkg::CNT_W'(pcs_pkg::LOSS_CYCLES)) begin
                idle_cnt_d[i] = idle_cnt_q[i] + pcs_pkg::CNT_W'(1);
                // still for the limit: flag the input
                if (idle_cnt_d[i] == pcs_pkg::CNT_W'(pcs_pkg::LOSS_CYCLES)) begin
                    loss_d[i] = 1'b1;
                end
            end
        end
    end

    // sample registers double as the previous value of the change detector
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            smp_q <= 2'b00;
            smp_vld_q <= 1'b0;
            idle_cnt_q[0] <= '0;
            idle_cnt_q[1] <= '0;
            loss_q <= 2'b00;
        end else begin
            smp_q <= smp_d;
            smp_vld_q <= smp_vld_d;
            idle_cnt_q[0] <= idle_cnt_d[0];
            idle_cnt_q[1] <= idle_cnt_d[1];
            loss_q <= loss_d;
        end
    end

    // =========================================================
    // manual request qualification
    // =========================================================
    // the pin and the software bit are ored; a rising edge arms a counter
    // and the request fires once after it has stayed high long enough
    // a request held high for a long time fires only once: the arm flag is
    // dropped on firing and comes back only after the request goes low
    // a request that falls before the count is simply forgotten
    assign req_level = manual_switch_i | swreq_q;

    always_comb begin
        req_prev_d = req_level;
        hold_cnt_d = hold_cnt_q;
        armed_d = armed_q;
        manual_fire = 1'b0;
        if (!req_level) begin
            armed_d = 1'b0;
            hold_cnt_d = '0;
        end else if (!req_prev_q) begin
            armed_d = 1'b1;
            hold_cnt_d = pcs_pkg::CNT_W'(1);
        end else if (armed_q) begin
            hold_cnt_d = hold_cnt_q + pcs_pkg::CNT_W'(1);
            // held for the full count since the rising edge
            if (hold_cnt_d == pcs_pkg::CNT_W'(pcs_pkg::MANUAL_HOLD_CYCLES)) begin
                manual_fire = 1'b1;
                armed_d = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_prev_q <= 1'b0;
            hold_cnt_q <= '0;
            armed_q <= 1'b0;
        end else begin
            req_prev_q <= req_prev_d;
            hold_cnt_q <= hold_cnt_d;
            armed_q <= armed_d;
        end
    end

    // =========================================================
    // switchover state machine and reference mux
    // =========================================================
    // a switch is first requested, then carried out on a falling edge of
    // the input being switched to, so the muxed output never gets a runt
    // the old input is either dead or being dropped on purpose, so an edge of
    // the new one is the only edge that is sure to come
    // no new request is taken while one is pending; it is ignored
    always_comb begin
        target = ~sel_q;
        manual_en = (mode_q == pcs_pkg::PCS_MODE_MANUAL) || (mode_q == pcs_pkg::PCS_MODE_AUTO_OVR);
        // override mode gives the request a veto: a high request freezes auto selection
        auto_en = (mode_q == pcs_pkg::PCS_MODE_AUTO) ||
                  ((mode_q == pcs_pkg::PCS_MODE_AUTO_OVR) && !req_level);
        // active lost and the other alive; both dead starts nothing
        auto_fire = auto_en && loss_q[sel_q] && !loss_q[target];
        state_d = state_q;
        sel_d = sel_q;
        switched_d = 1'b0;
        swcount_d = swcount_q;
        case (state_q)
            PCS_ST_RUN: begin
                if (auto_fire || (manual_en && manual_fire)) begin
                    state_d = PCS_ST_PEND;
                end
            end
            PCS_ST_PEND: begin
                if (loss_q[target]) begin
                    // the target died while waiting: stay put, nothing to switch to
                    state_d = PCS_ST_RUN;
                end else if (smp_q[target] && !ref_in[target]) begin
                    // falling edge of the surviving input
                    sel_d = target;
                    state_d = PCS_ST_RUN; // back to watching, no limit on repeats
                    switched_d = 1'b1;
                    // the count wraps silently once it fills
                    swcount_d = swcount_q + pcs_pkg::SWCOUNT_W'(1);
                end
            end
            default: begin
                state_d = PCS_ST_RUN;
            end
        endcase
        // sampled copy of the selected reference feeds the loop
        // using the next select keeps the copy in step with the indicator
        ref_d = sel_d ? ref_in[1] : ref_in[0];
    end

    // the mux starts on the primary input, matching the indicator
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q <= PCS_ST_RUN;
            sel_q <= pcs_pkg::SEL_RESET;
            ref_q <= 1'b0;
            switched_q <= 1'b0;
            swcount_q <= '0;
        end else begin
            state_q <= state_d;
            sel_q <= sel_d;
            ref_q <= ref_d;
            switched_q <= switched_d;
            swcount_q <= swcount_d;
        end
    end

    // =========================================================
    // apb register slave
    // =========================================================
    // one wait state: pready rises in the second access cycle; read data is
    // loaded at that same edge, writes take effect one edge later, while pready is high
    // status and count writes are ignored without an error, so software may
    // write the whole map back without tripping pslverr
    // pready is a one-cycle pulse; a master that keeps penable high a cycle
    // too long starts a second access
    assign access = psel_i && penable_i && !pready_q;

    always_comb begin
        mode_d = mode_q;
        swreq_d = swreq_q;
        prdata_d = prdata_q;
        pready_d = 1'b0;
        pslverr_d = 1'b0;
        if (access) begin
            pready_d = 1'b1;
            prdata_d = 32'h0000_0000;
            if (reg_slot(paddr_i) == 2'd0) begin
                prdata_d[pcs_pkg::CTRL_MODE_LSB +: 2] = mode_q;
                prdata_d[pcs_pkg::CTRL_SWREQ_BIT] = swreq_q;
            end else if (reg_slot(paddr_i) == 2'd1) begin
                // status is read only
                prdata_d[pcs_pkg::STATUS_LOSS0_BIT] = loss_q[0];
                prdata_d[pcs_pkg::STATUS_LOSS1_BIT] = loss_q[1];
                prdata_d[pcs_pkg::STATUS_ACTIVE_BIT] = sel_q;
                prdata_d[pcs_pkg::STATUS_PEND_BIT] = (state_q == PCS_ST_PEND);
            end else if (reg_slot(paddr_i) == 2'd2) begin
                prdata_d[pcs_pkg::SWCOUNT_W-1:0] = swcount_q;
            end else begin
                pslverr_d = 1'b1;
            end
        end
        if (psel_i && penable_i && pready_q && pwrite_i) begin
            if (reg_slot(paddr_i) == 2'd0) begin
                // mode code 3 is not a mode; keep the old one
                // a stray write of all ones thus leaves the block in a known mode
                if (pwdata_i[pcs_pkg::CTRL_MODE_LSB +: 2] != 2'b11) begin
                    mode_d = pwdata_i[pcs_pkg::CTRL_MODE_LSB +: 2];
                end
                swreq_d = pwdata_i[pcs_pkg::CTRL_SWREQ_BIT];
            end
        end
    end

    // out of reset the block watches on its own, in automatic mode
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            mode_q <= pcs_pkg::CTRL_MODE_RESET;
            swreq_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            swreq_q <= swreq_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // =========================================================
    // outputs, all straight from flip-flops
    // =========================================================
    // flags are only meaningful when both references are near one rate
    // the selected-input indicator is the one status that holds at any rate
    // ref_clock_o lags the selected input by one cycle, the cost of a registered output
    assign loss_flag_o = loss_q;
    assign active_input_o = sel_q;
    assign ref_clock_o = ref_q;
    assign switched_o = switched_q;
    assign prdata_o = prdata_q;
    assign pready_o = pready_q;
    assign pslverr_o = pslverr_q;

endmodule

`default_nettype wire

//--- testbench/pcs_ref_source.sv
// Purpose: model of the two reference clock sources
// Assumes: sources run off clk_i, HALF cycles per half period
// Notes: a stopped source sits low, as a dead oscillator would
`timescale 1ns/100ps
`default_nettype none
module pcs_ref_source #(
    parameter int HALF = 2
) (
    input wire logic clk_i,
    input wire logic [1:0] stop_i,
    output logic primary_o,
    output logic backup_o
);
    logic ph_q = 1'b0;
    logic [7:0] cnt_q = 8'h00;
    // ==========================================
    // divider
    // one divider for both keeps the rates equal, so the flags stay valid
    always @(posedge clk_i) begin
        cnt_q <= (cnt_q == 8'(HALF - 1)) ? 8'h00 : cnt_q + 8'h01;
        if (cnt_q == 8'(HALF - 1)) begin
            ph_q <= ~ph_q;
        end
    end
    // the backup source is wired to the second input
    assign primary_o = ph_q & ~stop_i[0];
    assign backup_o = ph_q & ~stop_i[1];
endmodule
`default_nettype wire

//--- testbench/pcs_switchover_assertions.sv
// Purpose: port-level checks for the switchover block
// Assumes: one clock domain, reset active high
// Notes: flag windows allow for an input sampling stage
`timescale 1ns/100ps
`default_nettype none
module pcs_switchover_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic [31:0] prdata_o,
    input wire logic primary_ref_clock_i,
    input wire logic backup_ref_clock_i,
    input wire logic [1:0] loss_flag_o,
    input wire logic active_input_o,
    input wire logic switched_o,
    input wire logic ref_clock_o
);
    // ==========================================
    // properties
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_access;
        psel_i && penable_i && !pready_o;
    endsequence
    sequence s_prim_still;
        $stable(primary_ref_clock_i) [*3];
    endsequence
    a_reset_clear: assert property ($past(rst_i) |-> !active_input_o && loss_flag_o == 2'b00)
        else $error("state not clear after reset");
    a_ready_wait: assert property (s_access |=> pready_o)
        else $error("ready not one cycle after access");
    a_ready_pulse: assert property (pready_o |=> !pready_o)
        else $error("ready held too long");
    a_error_data: assert property (pready_o && pslverr_o |-> prdata_o == 32'h0)
        else $error("error response carries data");
    a_switch_pulse: assert property ($changed(active_input_o) |-> ##[0:1] switched_o)
        else $error("switch without pulse");
    a_pulse_single: assert property (switched_o |=> !switched_o)
        else $error("switch pulse too long");
    a_falling_edge: assert property ($changed(active_input_o) |->
        (active_input_o ? !$past(backup_ref_clock_i) : !$past(primary_ref_clock_i)))
        else $error("switch not after target falling edge");
    a_loss_raise: assert property (s_prim_still |-> ##[0:3] loss_flag_o[0])
        else $error("stopped primary not flagged");
    a_loss_clear: assert property ($changed(backup_ref_clock_i) |-> ##[1:3] !loss_flag_o[1])
        else $error("toggling backup still flagged");
    a_dead_hold: assert property (loss_flag_o == 2'b11 |=> $stable(active_input_o))
        else $error("switch with both inputs lost");
    a_ref_follow: assert property (!$past(rst_i) |->
        ref_clock_o == (active_input_o ? $past(backup_ref_clock_i) : $past(primary_ref_clock_i)))
        else $error("muxed reference does not follow the selected input");
endmodule
bind pcs_switchover pcs_switchover_assertions u_chk (.clk_i, .rst_i, .psel_i, .penable_i, .pready_o,
    .pslverr_o, .prdata_o, .primary_ref_clock_i, .backup_ref_clock_i, .loss_flag_o, .active_input_o,
    .switched_o, .ref_clock_o);
`default_nettype wire

//--- testbench/pcs_switchover_tb_top.sv
// Purpose: self-checking bench for the switchover block
// Assumes: references run at clk_i / 4 from the source model
// Notes: mode and counters are reached over apb
`timescale 1ns/100ps
`default_nettype none
module pcs_switchover_tb_top;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, man = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, active, switched, prim, bkup, e;
    logic [1:0] loss;
    logic [1:0] stop = 2'b00;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    int pulses = 0;
    initial begin
        forever #50 clk_i = ~clk_i;
    end
    pcs_ref_source src (.clk_i(clk_i), .stop_i(stop), .primary_o(prim), .backup_o(bkup));
    pcs_switchover uut (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .primary_ref_clock_i(prim), .backup_ref_clock_i(bkup), .manual_switch_i(man), .ref_clock_o(),
        .loss_flag_o(loss), .active_input_o(active), .switched_o(switched));
    // ==========================================
    // helpers
    task automatic check(string name, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    // request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // no cycle limit here: a missing pready is caught by the bench timeout
        do begin
            @(posedge clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic wait_act(input logic exp, input int lim);
        repeat (lim) begin
            if (active !== exp) begin
                @(posedge clk_i);
            end
        end
        check("active", exp, active);
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // counts switch pulses and cuts a hang short
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (switched === 1'b1) begin
            pulses <= pulses + 1;
        end
        if (cycles == 20000) begin
            $display("Error cycles expected below %0d seen %0d", 20000, cycles);
            failures++;
            test_done();
        end
    end
    // ==========================================
    // scenarios
    task automatic t_reset();
        check("loss", 2'b00, loss);
        check("active", 1'b0, active);
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", pcs_pkg::CTRL_MODE_RESET, rd);
        apb(1'b0, 8'h0C, 32'h0);
        check("unmapped", 1'b1, e);
        apb(1'b1, 8'h04, 32'hFFFF_FFFF);
        apb(1'b0, 8'h04, 32'h0);
        check("status", 32'h0, rd);
    endtask
    task automatic t_auto();
        stop <= 2'b01;
        wait_act(1'b1, 40);
        apb(1'b0, 8'h04, 32'h0);
        check("status", 32'h5, rd);
        stop <= 2'b10;
        wait_act(1'b0, 40);
        stop <= 2'b11;
        repeat (30) @(posedge clk_i);
        check("dead", 1'b0, active);
        stop <= 2'b00;
        repeat (10) @(posedge clk_i);
    endtask
    task automatic t_manual();
        apb(1'b1, 8'h00, 32'h0);
        man <= 1'b1;
        repeat (3) @(posedge clk_i);
        man <= 1'b0;
        wait_act(1'b1, 20);
        man <= 1'b1;
        repeat (2) @(posedge clk_i);
        man <= 1'b0;
        repeat (20) @(posedge clk_i);
        check("short req", 1'b1, active);
    endtask
    task automatic t_override();
        apb(1'b1, 8'h00, 32'h2);
        apb(1'b1, 8'h00, 32'h3);
        apb(1'b0, 8'h00, 32'h0);
        check("mode", 32'h2, rd);
        man <= 1'b1;
        wait_act(1'b0, 20);
        stop <= 2'b01;
        repeat (30) @(posedge clk_i);
        check("override", 1'b0, active);
        man <= 1'b0;
        wait_act(1'b1, 40);
        stop <= 2'b00;
        apb(1'b0, 8'h08, 32'h0);
        check("swcount", 32'h5, rd);
        check("pulses", 5, pulses);
    endtask
    // a reset after the switches, as a user restoring phase would apply; all starts over
    task automatic t_rearm();
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("loss", 2'b00, loss);
        check("active", 1'b0, active);
        apb(1'b0, 8'h00, 32'h0);
        check("ctrl", pcs_pkg::CTRL_MODE_RESET, rd);
        apb(1'b1, 8'h00, 32'h10);
        wait_act(1'b1, 20);
        apb(1'b0, 8'h08, 32'h0);
        check("swcount", 32'h1, rd);
    endtask
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_reset();
        t_auto();
        t_manual();
        t_override();
        t_rearm();
        test_done();
    end
endmodule
`default_nettype wire
